/* File: verilog/sadc_control.sv */
// Purpose: register file and conversion sequencer of a 10-bit SAR converter
// Assumes: classic Wishbone slave, comparator and RC clock arrive asynchronously
// Notes: the analog core follows analogCtl; its comparator answers on compPin
// Behaviour
// [R1] Each conversion yields a 10-bit binary result of the selected input.
// [R2] Channel code in control bits 5:2: 0..12 external, 14 core supply, 15 band-gap.
// [R3] Unimplemented channel codes may convert to any value.
// [R4] Control bit 7 picks negative reference, bit 6 positive reference.
// [R5] Control bit 1 reads 1 during conversion, 0 when idle, while enabled.
// [R6] Control bit 0 switches the converter on and off.
// [R7] Setup bit 7 selects right (1) or left (0) justified result.
// [R8] Setup bit 6 requests calibration on the next conversion.
// [R9] Setup bits 5:3 give acquisition length: 0,2,4,6,8,12,16,20 periods.
// [R10] Setup bits 2:0 pick divider 2,8,32,RC,4,16,64 for the conversion clock.
// [R11] With RC clock, one instruction cycle passes before the clock runs.
// [R12] Set pin bit means digital; clear means analog with digital input zero.
// [R13] Reset returns all analog-capable pins to analog.
// [R14] Low pin register bits 7:0 map to channels 7:0; 7:5 large package only.
// [R15] Software powers the band-gap before converting channel 15.
// [R16] Band-gap stays on while any module requests it.
// [R17] Software waits 10 ms after band-gap turn-on before measuring.
// [R18] Small package lacks channels 5..7 and their configuration bits.
// [R19] Completion loads result, clears start bit and sets the done flag.
// [R20] Nonzero acquisition code samples first, then converts; zero converts at once.
// [R21] At least two conversion clock periods pass before the next acquisition.
// [R22] Reset restores registers, turns the converter off, aborts conversion; the result pair is not reset and keeps its content.
// [R23] Start with the converter disabled does nothing.
// [R24] Result pair is 16 bits, six unused positions read zero.
`timescale 1ns/1ps
`default_nettype none
module sadc_control #(
  parameter int NUM_PINS = 13,
  parameter bit LARGE_PKG = 1'b1,
  parameter int NUM_BG_REQ = 3
) (
  input wire logic clk_sys, // system clock, 100 MHz
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [sadc_pkg::ADDR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lane selects
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // access acknowledge
  input wire logic rcClkPin, // internal RC oscillator
  input wire logic compPin, // comparator: input at or above trial level
  input wire logic [NUM_PINS-1:0] pinDigIn, // raw digital pin levels
  output logic [NUM_PINS-1:0] pinDigOut, // gated digital pin readings
  output logic [NUM_PINS-1:0] pinAnalog, // pin used as analog input
  input wire logic [NUM_BG_REQ-1:0] otherBgRequests, // band-gap requests of other modules
  output logic bandgapOn, // band-gap reference powered
  output logic conversionDoneFlag, // sticky conversion complete flag
  output sadc_pkg::sadc_analog_s analogCtl // drive to the analog core
);
  import sadc_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV, ST_GAP} sadc_state_e;

  localparam logic [12:0] PIN_MASK = LARGE_PKG ? 13'h1fff : 13'h1f1f;

  logic [7:0] ctrlReg;
  logic [7:0] setupReg;
  logic [7:0] pinLow;
  logic [4:0] pinHighCfg;
  logic bgReq;
  logic [RESULT_BITS-1:0] result;
  logic [RESULT_BITS-1:0] sar;
  logic [RESULT_BITS-1:0] trialBit;
  logic [4:0] tadCnt;
  logic [2:0] settleCnt;
  logic convDone;
  sadc_state_e state;
  logic tadTick;
  logic run;
  logic wbAccess;
  logic wbWrite;
  logic [11:0] wbIdx;
  logic [7:0] wdata;
  logic [7:0] rdData;
  logic [7:0] resHigh;
  logic [7:0] resLow;
  logic [4:0] acqLen;
  logic [12:0] pinCfg;
  logic cS1, cS2, cS3, compHigh;

  assign wbAccess = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wbWrite = wbAccess && wb_we_i && wb_sel_i[0];
  assign wbIdx = wb_adr_i[ADDR_W-1:2];
  assign wdata = wb_dat_i[7:0];
  assign pinCfg = {pinHighCfg, pinLow} & PIN_MASK;
  assign run = (state != ST_IDLE);

  always_comb begin
    case (setupReg[SET_ACQ_LSB +: 3]) // [R9]
      3'h0: acqLen = 5'h00;
      3'h1: acqLen = 5'h02;
      3'h2: acqLen = 5'h04;
      3'h3: acqLen = 5'h06;
      3'h4: acqLen = 5'h08;
      3'h5: acqLen = 5'h0c;
      3'h6: acqLen = 5'h10;
      default: acqLen = 5'h14;
    endcase
  end

  // Justification is applied on read, so flipping the format bit
  // re-presents the last result without a new conversion
  always_comb begin
    if (setupReg[SET_JUSTIFY]) begin
      resHigh = {6'h00, result[9:8]}; // [R7] [R24]
      resLow = result[7:0];
    end else begin
      resHigh = result[9:2]; // [R7] [R24]
      resLow = {result[1:0], 6'h00};
    end
  end

  always_comb begin
    case (wbIdx)
      IDX_CONTROL: rdData = ctrlReg; // [R5]
      IDX_SETUP: rdData = setupReg;
      IDX_PIN_LOW: rdData = pinLow;
      IDX_PIN_HIGH: rdData = {bgReq, 2'b00, pinHighCfg};
      IDX_STATUS: rdData = {7'h00, conversionDoneFlag};
      IDX_RES_HIGH: rdData = resHigh;
      IDX_RES_LOW: rdData = resLow;
      default: rdData = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wbAccess;
      if (wbAccess) begin
        wb_dat_o <= {24'h00_0000, rdData};
      end
    end
  end

  // Control register: the start bit only sticks while the enable bit is 1
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrlReg <= RST_CONTROL; // [R22]
    end else if (wbWrite && wbIdx == IDX_CONTROL) begin
      ctrlReg <= wdata;
      ctrlReg[CTL_GO] <= wdata[CTL_GO] && wdata[CTL_EN]; // [R23] [R6]
    end else if (convDone || !ctrlReg[CTL_EN]) begin
      ctrlReg[CTL_GO] <= 1'b0; // [R19] [R5]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      setupReg <= RST_SETUP;
    end else if (wbWrite && wbIdx == IDX_SETUP) begin
      setupReg <= wdata;
    end
  end

  // Absent pins on the small package keep their bits at zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pinLow <= RST_PIN_LOW; // [R13]
      pinHighCfg <= RST_PIN_HIGH[4:0];
      bgReq <= RST_PIN_HIGH[HIGH_BG_REQ];
    end else if (wbWrite && wbIdx == IDX_PIN_LOW) begin
      pinLow <= wdata & PIN_MASK[7:0]; // [R14] [R18]
    end else if (wbWrite && wbIdx == IDX_PIN_HIGH) begin
      pinHighCfg <= wdata[4:0];
      bgReq <= wdata[HIGH_BG_REQ];
    end
  end

  // A completion in the same cycle as a clear keeps the flag set
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      conversionDoneFlag <= 1'b0;
    end else if (convDone) begin
      conversionDoneFlag <= 1'b1; // [R19]
    end else if (wbWrite && wbIdx == IDX_STATUS && wdata[STAT_DONE]) begin
      conversionDoneFlag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bandgapOn <= 1'b0;
    end else begin
      bandgapOn <= bgReq || (|otherBgRequests); // [R16]
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      logic s1, s2, s3, stable;
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          stable <= 1'b0;
          pinDigOut[gi] <= 1'b0;
          pinAnalog[gi] <= 1'b0;
        end else begin
          s1 <= pinDigIn[gi];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            stable <= s3;
          end
          pinDigOut[gi] <= stable && pinCfg[gi]; // [R12]
          pinAnalog[gi] <= !pinCfg[gi] && PIN_MASK[gi]; // [R12] [R18]
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cS1 <= 1'b0;
      cS2 <= 1'b0;
      cS3 <= 1'b0;
      compHigh <= 1'b0;
    end else begin
      cS1 <= compPin;
      cS2 <= cS1;
      cS3 <= cS2;
      if (cS2 == cS3) begin
        compHigh <= cS3;
      end
    end
  end

  sadc_tad_gen #(
    .TCY_CYC(TCY_CYCLES)
  ) u_tad (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .run(run),
    .clkSel(setupReg[SET_CLK_LSB +: 3]),
    .rcClkPin(rcClkPin),
    .tadTick(tadTick)
  );

  // Clearing the enable bit aborts whatever is in flight
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !ctrlReg[CTL_EN]) begin
      state <= ST_IDLE; // [R22]
      tadCnt <= 5'h00;
      settleCnt <= 3'h0;
      sar <= '0;
      trialBit <= '0;
      convDone <= 1'b0;
    end else begin
      convDone <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (ctrlReg[CTL_GO]) begin
            sar <= '0;
            if (acqLen == 5'h00) begin
              state <= ST_CONV; // [R20]
              trialBit <= SAR_MSB;
              settleCnt <= 3'(COMP_SETTLE - 1);
            end else begin
              state <= ST_ACQ; // [R20]
              tadCnt <= acqLen;
            end
          end
        end
        ST_ACQ: begin
          if (tadTick) begin
            if (tadCnt == 5'h01) begin
              state <= ST_CONV; // [R20]
              trialBit <= SAR_MSB;
              settleCnt <= 3'(COMP_SETTLE - 1);
            end else begin
              tadCnt <= tadCnt - 5'h01;
            end
          end
        end
        ST_CONV: begin
          // MSB first; a bit waits for a period edge after the comparator caught up
          if (tadTick && settleCnt == 3'h0) begin
            if (compHigh) begin
              sar <= sar | trialBit; // [R1]
            end
            trialBit <= trialBit >> 1;
            settleCnt <= 3'(COMP_SETTLE - 1);
            if (trialBit[0]) begin
              convDone <= 1'b1; // [R19]
              state <= ST_GAP;
              tadCnt <= GAP_TADS; // [R21]
            end
          end else if (settleCnt != 3'h0) begin
            settleCnt <= settleCnt - 3'h1;
          end
        end
        ST_GAP: begin
          if (tadTick) begin
            if (tadCnt == 5'h01) begin
              state <= ST_IDLE; // [R21]
            end else begin
              tadCnt <= tadCnt - 5'h01;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // The result pair keeps its content across reset; it is data, not control
  always_ff @(posedge clk_sys) begin
    if (state == ST_CONV && tadTick && settleCnt == 3'h0 && trialBit[0] && ctrlReg[CTL_EN]) begin
      result <= compHigh ? (sar | trialBit) : sar; // [R19] [R1]
    end
  end

  // Reserved channel codes are passed through; the core may return anything
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      analogCtl <= '0;
    end else begin
      analogCtl.enable <= ctrlReg[CTL_EN]; // [R6]
      analogCtl.negRefExt <= ctrlReg[CTL_NEG_REF]; // [R4]
      analogCtl.posRefExt <= ctrlReg[CTL_POS_REF]; // [R4]
      analogCtl.channel <= ctrlReg[CTL_CHAN_LSB +: 4]; // [R2] [R3]
      analogCtl.sampling <= ctrlReg[CTL_EN] && state != ST_CONV;
      analogCtl.calibrate <= setupReg[SET_CAL] && state == ST_CONV; // [R8]
      analogCtl.trial <= (state == ST_CONV) ? (sar | trialBit) : '0;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/sadc_pkg.sv */
// Purpose: shared constants and types for the SAR converter control block
// Assumes: 32-bit classic Wishbone, registers at byte address 4 * index
// Notes: indices are word indices; data sits in bits 7:0
package sadc_pkg;
  localparam int ADDR_W = 14;
  localparam int RESULT_BITS = 10;

  localparam logic [11:0] IDX_PIN_LOW = 12'hf48;
  localparam logic [11:0] IDX_PIN_HIGH = 12'hf49;
  localparam logic [11:0] IDX_STATUS = 12'hfc0;
  localparam logic [11:0] IDX_SETUP = 12'hfc1;
  localparam logic [11:0] IDX_CONTROL = 12'hfc2;
  localparam logic [11:0] IDX_RES_LOW = 12'hfc3;
  localparam logic [11:0] IDX_RES_HIGH = 12'hfc4;

  localparam int CTL_NEG_REF = 7;
  localparam int CTL_POS_REF = 6;
  localparam int CTL_CHAN_LSB = 2;
  localparam int CTL_GO = 1;
  localparam int CTL_EN = 0;
  localparam int SET_JUSTIFY = 7;
  localparam int SET_CAL = 6;
  localparam int SET_ACQ_LSB = 3;
  localparam int SET_CLK_LSB = 0;
  localparam int HIGH_BG_REQ = 7;
  localparam int STAT_DONE = 0;

  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_SETUP = 8'h00;
  localparam logic [7:0] RST_PIN_LOW = 8'h00;
  localparam logic [7:0] RST_PIN_HIGH = 8'h00;

  localparam logic [2:0] CLK_CODE_RC = 3'h3;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TCY_NS = 40;
  localparam int TCY_CYCLES = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] GAP_TADS = 5'h02;
  localparam logic [9:0] SAR_MSB = 10'h200;
  // System clocks from a new trial level until the synchronised comparator shows it
  localparam int COMP_SETTLE = 6;

  typedef struct packed {
    logic enable;
    logic negRefExt;
    logic posRefExt;
    logic [3:0] channel;
    logic sampling;
    logic calibrate;
    logic [RESULT_BITS-1:0] trial;
  } sadc_analog_s;
endpackage

/* File: verilog/sadc_tad_gen.sv */
// Purpose: conversion clock tick generator, divider or internal RC clock
// Assumes: rcClkPin is asynchronous to clk_sys and much slower than it
// Notes: tadTick is a one-cycle enable pulse, one per conversion clock period
`timescale 1ns/1ps
`default_nettype none
module sadc_tad_gen #(
  parameter int TCY_CYC = sadc_pkg::TCY_CYCLES
) (
  input wire logic clk_sys, // system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic run, // sequencer needs conversion clock periods
  input wire logic [2:0] clkSel, // conversion clock select code
  input wire logic rcClkPin, // internal RC oscillator, asynchronous
  output logic tadTick // one pulse per conversion clock period
);
  import sadc_pkg::*;

  logic [5:0] divCnt;
  logic [5:0] divLast;
  logic rcS1, rcS2, rcS3, rcStable;
  logic rcEdge;
  logic [7:0] dlyCnt;
  logic useRc;

  assign useRc = (clkSel == CLK_CODE_RC);

  always_comb begin
    case (clkSel) // [R10]
      3'h0: divLast = 6'h01;
      3'h1: divLast = 6'h07;
      3'h2: divLast = 6'h1f;
      3'h4: divLast = 6'h03;
      3'h5: divLast = 6'h0f;
      3'h6: divLast = 6'h3f;
      default: divLast = 6'h01;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || !run || useRc) begin
      divCnt <= 6'h00;
    end else if (divCnt == divLast) begin
      divCnt <= 6'h00;
    end else begin
      divCnt <= divCnt + 6'h01;
    end
  end

  // Only the agreeing second and third stages decide a level change
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rcS1 <= 1'b0;
      rcS2 <= 1'b0;
      rcS3 <= 1'b0;
      rcStable <= 1'b0;
    end else begin
      rcS1 <= rcClkPin;
      rcS2 <= rcS1;
      rcS3 <= rcS2;
      if (rcS2 == rcS3) begin
        rcStable <= rcS3;
      end
    end
  end

  assign rcEdge = (rcS2 == rcS3) && rcS3 && !rcStable;

  // Holds the RC clock off for one instruction cycle after each start
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !run) begin
      dlyCnt <= 8'(TCY_CYC);
    end else if (dlyCnt != 8'h00) begin
      dlyCnt <= dlyCnt - 8'h01; // [R11]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || !run) begin
      tadTick <= 1'b0;
    end else if (useRc) begin
      tadTick <= rcEdge && (dlyCnt == 8'h00); // [R11]
    end else begin
      tadTick <= (divCnt == divLast);
    end
  end
endmodule
`default_nettype wire

/* File: verification/sadc_analog_model.sv */
// Purpose: analog side of the converter: input levels, comparator, RC oscillator
// Assumes: each channel carries a level made from its code and the reference picks
// Notes: the comparator toggles while the core is off so no stale answer survives
`timescale 1ns/1ps
`default_nettype none
module sadc_analog_model (
  input wire logic clk_sys, // system clock
  input wire sadc_pkg::sadc_analog_s analogCtl, // core control from the block
  output logic compPin, // comparator answer
  output logic rcClkPin // free-running RC oscillator
);
  import sadc_pkg::*;
  logic [9:0] level;
  logic toggle = 1'b0;
  // Level depends on channel and both reference picks
  assign level = {analogCtl.channel, 4'h5, analogCtl.negRefExt, analogCtl.posRefExt};
  always @(posedge clk_sys) toggle <= ~toggle;
  assign compPin = analogCtl.enable ? (level >= analogCtl.trial) : toggle;
  // Band-gap level is ideal here, so no settling wait is needed before use
  // Odd offset keeps the oscillator edges clear of the clk_sys edges
  initial begin
    rcClkPin = 1'b0;
    #3;
    forever #65 rcClkPin = ~rcClkPin;
  end
endmodule
`default_nettype wire

/* File: verification/sadc_control_chk.sv */
// Purpose: port-level assertions for the converter control block
// Assumes: one clock domain, synchronous active-high reset
// Notes: bound to the top module from the testbench file
`timescale 1ns/1ps
`default_nettype none
module sadc_control_chk #(
  parameter int NUM_PINS = 13,
  parameter int NUM_BG_REQ = 3
) (
  input wire logic clk_sys, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // acknowledge
  input wire logic [NUM_PINS-1:0] pinDigOut, // gated digital readings
  input wire logic [NUM_PINS-1:0] pinAnalog, // analog pin marks
  input wire logic [NUM_BG_REQ-1:0] otherBgRequests, // other band-gap users
  input wire logic bandgapOn, // band-gap powered
  input wire logic conversionDoneFlag, // done flag
  input wire sadc_pkg::sadc_analog_s analogCtl // core control
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not given one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  pin_gate_a: assert property ((pinDigOut & pinAnalog) == '0)
    else $error("analog pin shows a digital reading");
  pin_rst_a: assert property ($fell(sys_rst) |=> pinAnalog == {NUM_PINS{1'b1}})
    else $error("pins not analog after reset");
  bg_other_a: assert property (|otherBgRequests |=> bandgapOn)
    else $error("band-gap off while another module requests it");
  rst_off_a: assert property ($fell(sys_rst) |-> !analogCtl.enable && !conversionDoneFlag)
    else $error("converter or flag active after reset");
  idle_cal_a: assert property (!analogCtl.enable [*2] |-> !analogCtl.calibrate)
    else $error("calibration while converter off");
  cover property ($rose(conversionDoneFlag));
  cover property ($rose(bandgapOn));
  cover property ($rose(analogCtl.calibrate));
endmodule
`default_nettype wire

/* File: verification/tb_sadc_control.sv */
// Purpose: self-checking bench for the converter control block
// Assumes: analog model answers the comparator; bench drives pins and bus
// Notes: conversion lengths compared with small tolerance for divider phase
`timescale 1ns/1ps
`default_nettype none
module tb_sadc_control;
  import sadc_pkg::*;
  localparam logic [11:0] REGS[3] = '{IDX_PIN_LOW, IDX_SETUP, IDX_CONTROL};
  localparam int ACQ[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  localparam logic [2:0] CLKC[5] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  localparam int DIV[5] = '{8, 32, 4, 16, 64};
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, rcClk, comp, bgOn, done;
  logic [12:0] pinIn = '0;
  logic [12:0] pinOut, pinAna;
  logic [2:0] bgReq = '0;
  sadc_analog_s actl;
  int compares = 0;
  int n_mismatch = 0;
  initial forever #5 clk_sys = ~clk_sys;
  sadc_control i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rcClkPin(rcClk), .compPin(comp), .pinDigIn(pinIn), .pinDigOut(pinOut),
    .pinAnalog(pinAna), .otherBgRequests(bgReq), .bandgapOn(bgOn),
    .conversionDoneFlag(done), .analogCtl(actl));
  sadc_analog_model i_model (.clk_sys(clk_sys), .analogCtl(actl), .compPin(comp),
    .rcClkPin(rcClk));
  task automatic stop_test;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp=%h got=%h", nm, e, g);
    end
  endtask
  task automatic chk_t(input string nm, input int e, input int g, input int tol);
    compares++;
    if (g < e - tol || g > e + tol) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp=%0d got=%0d", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // One edge passes first so cyc stays low a cycle between transfers
  task automatic wb(input logic w, input logic [11:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      n_mismatch++;
      stop_test();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic go(input logic [7:0] su, input logic [7:0] ct);
    wb(1'b1, IDX_STATUS, 8'h01);
    wb(1'b1, IDX_SETUP, su);
    wb(1'b1, IDX_CONTROL, ct | 8'h03);
  endtask
  task automatic conv(input logic [7:0] su, input logic [7:0] ct, output int t);
    logic [9:0] v;
    go(su, ct);
    chk("flag clear", 32'h0, 32'(done));
    t = 0;
    while (done !== 1'b1 && t < 3000) begin
      @(negedge clk_sys);
      t++;
    end
    if (t >= 3000) begin
      n_mismatch++;
      stop_test();
    end
    v = {ct[5:2], 4'h5, ct[7], ct[6]};
    wb(1'b0, IDX_CONTROL, 8'h00);
    chk("go cleared", 32'(ct | 8'h01), q);
    wb(1'b0, IDX_RES_HIGH, 8'h00);
    chk("res high", su[7] ? 32'(v[9:8]) : 32'(v[9:2]), q);
    wb(1'b0, IDX_RES_LOW, 8'h00);
    chk("res low", su[7] ? 32'(v[7:0]) : 32'({v[1:0], 6'h0}), q);
    // Lets the post-conversion gap end so the next start is not held
    tick(130);
  endtask
  initial begin
    int t0, t;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    foreach (REGS[i]) begin
      wb(1'b0, REGS[i], 8'h00);
      chk("reset reg", 32'h0, q);
    end
    chk("pins analog", 32'h1fff, 32'(pinAna));
    wb(1'b0, 12'h100, 8'h00);
    chk("unmapped", 32'h0, q);
    pinIn <= 13'h1fff;
    wb(1'b1, IDX_PIN_LOW, 8'ha5);
    wb(1'b1, IDX_PIN_HIGH, 8'h7f);
    wb(1'b0, IDX_PIN_HIGH, 8'h00);
    chk("pin high", 32'h1f, q);
    tick(6);
    chk("dig out", 32'h1fa5, 32'(pinOut));
    chk("analog", 32'h5a, 32'(pinAna));
    wb(1'b1, IDX_PIN_HIGH, 8'h80);
    bgReq <= 3'h4;
    tick(2);
    chk("bg on", 32'h1, 32'(bgOn));
    wb(1'b1, IDX_PIN_HIGH, 8'h00);
    tick(2);
    chk("bg held", 32'h1, 32'(bgOn));
    @(posedge clk_sys);
    bgReq <= 3'h0;
    tick(2);
    chk("bg off", 32'h0, 32'(bgOn));
    for (int k = 0; k < 8; k++) begin
      if (k == 7) wb(1'b1, IDX_PIN_HIGH, 8'h80);
      conv({k[0], 1'b0, 3'(k), 3'h0}, {k[1:0], ((k == 7) ? 4'hf : 4'(2 * k)), 2'h0}, t);
      if (k == 0) t0 = t;
      chk_t("acq len", t0 + 2 * ACQ[k], t, 2);
    end
    for (int k = 0; k < 5; k++) begin
      // A bit needs a settled comparator and a period edge, so short periods stretch
      int per;
      per = ((COMP_SETTLE + DIV[k] - 1) / DIV[k]) * DIV[k];
      conv({5'h10, CLKC[k]}, 8'h24, t);
      chk_t("clk len", t0 + 10 * (per - ((COMP_SETTLE + 1) / 2) * 2), t, DIV[k]);
    end
    conv(8'h83, 8'h98, t);
    wb(1'b1, IDX_STATUS, 8'h01);
    wb(1'b1, IDX_CONTROL, 8'h02);
    tick(40);
    wb(1'b0, IDX_CONTROL, 8'h00);
    chk("no start", 32'h0, q);
    chk("no flag", 32'h0, 32'(done));
    go(8'h46, 8'h10);
    tick(10);
    chk("cal", 32'h1, 32'(actl.calibrate));
    chk("chan", 32'h4, 32'(actl.channel));
    wb(1'b1, IDX_CONTROL, 8'h00);
    tick(800);
    chk("abort", 32'h0, 32'(done));
    go(8'h06, 8'h00);
    tick(20);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    wb(1'b0, IDX_CONTROL, 8'h00);
    chk("rst ctl", 32'h0, q);
    wb(1'b0, IDX_PIN_LOW, 8'h00);
    chk("rst pins", 32'h0, q);
    chk("rst analog", 32'h1fff, 32'(pinAna));
    tick(800);
    chk("rst flag", 32'h0, 32'(done));
    stop_test();
  end
endmodule
bind sadc_control sadc_control_chk #(.NUM_PINS(NUM_PINS), .NUM_BG_REQ(NUM_BG_REQ)) i_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pinDigOut(pinDigOut), .pinAnalog(pinAnalog),
  .otherBgRequests(otherBgRequests), .bandgapOn(bandgapOn),
  .conversionDoneFlag(conversionDoneFlag), .analogCtl(analogCtl));
`default_nettype wire
